// ==== hw/stp_pkg.sv ====
package stp_pkg;

  // Width of one parallel word.
  localparam int WORD_W      = 4;
  // Divider counter width: counts input clocks modulo eight.
  localparam int DIV_W       = 3;
  // Counter value at which a word is complete in each mode.
  localparam logic [2:0] LAST_BIT4  = 3'h3;
  localparam logic [2:0] LAST_BIT8  = 3'h7;
  // Reset value of the divider counter.
  localparam logic [2:0] DIV_RST    = 3'h0;
  // Bit-slip pulse must be seen high for this many input clocks.
  localparam int SLIP_MIN_CLKS = 2;
  localparam logic [1:0] SLIP_MIN_CNT = 2'h2;

  typedef enum logic [1:0] {
    STP_SLIP_IDLE = 2'b00,
    STP_SLIP_WAIT = 2'b01,
    STP_SLIP_DONE = 2'b10
  } stp_slip_t;

  typedef struct packed {
    logic first_serial_input;
    logic second_serial_input;
    logic input_select;
  } stp_serial_t;

endpackage

// ==== hw/stp_conv.sv ====
`timescale 1ns/1ps

// Function
// - First received bit lands on output 0.
// - Derive quarter and eighth rate clocks.
// - Mode low: update outputs every four clocks.
// - Mode high: update outputs every eight clocks.
// - Select high picks first input, low second.
// - One bit shift per slip pulse held two clocks.
// - Slip swallows one clock in the dividers.
// - State undefined until master reset applied.
module stp_conv
  import stp_pkg::*;
#(
  parameter int WORD_WIDTH = 4
) (
  // Clock and reset.
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  // Serial inputs and selector.
  input  wire stp_pkg::stp_serial_t  SERIAL_IN,
  // Controls.
  input  wire logic                  CONV_MODE_8BIT,
  input  wire logic                  BIT_SLIP_INPUT,
  // Outputs.
  output logic [WORD_WIDTH-1:0]      PARALLEL_OUTPUTS,
  output logic                       QUARTER_RATE_CLOCK_OUT,
  output logic                       EIGHTH_RATE_CLOCK_OUT
);

  // The datapath is built for one fixed word width only.
  if (WORD_WIDTH != WORD_W) begin : g_width_check
    $error("WORD_WIDTH must equal 4");
  end

  // Pin synchronisers: two flops before any logic reads them.
  stp_serial_t ser_s1_q;
  stp_serial_t ser_s2_q;
  logic        mode_s1_q;
  logic        mode_s2_q;
  logic        slip_s1_q;
  logic        slip_s2_q;

  always_ff @(posedge CLK) begin
    ser_s1_q  <= SERIAL_IN;
    ser_s2_q  <= ser_s1_q;
    mode_s1_q <= CONV_MODE_8BIT;
    mode_s2_q <= mode_s1_q;
    slip_s1_q <= BIT_SLIP_INPUT;
    slip_s2_q <= slip_s1_q;
  end

  logic serial_bit;
  assign serial_bit = ser_s2_q.input_select ? ser_s2_q.first_serial_input
                                            : ser_s2_q.second_serial_input;

  // Bit-slip qualifier: one swallow per pulse held two clocks.
  stp_slip_t  slip_st_q;
  logic [1:0] slip_cnt_q;
  logic       swallow;

  assign swallow = (slip_st_q == STP_SLIP_WAIT) && slip_s2_q && (slip_cnt_q == SLIP_MIN_CNT - 2'h1);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      slip_st_q  <= STP_SLIP_IDLE;
      slip_cnt_q <= 2'h0;
    end else begin
      case (slip_st_q)
        STP_SLIP_IDLE: begin
          if (slip_s2_q) begin
            slip_st_q  <= STP_SLIP_WAIT;
            slip_cnt_q <= 2'h1;
          end
        end
        STP_SLIP_WAIT: begin
          if (!slip_s2_q) begin
            slip_st_q <= STP_SLIP_IDLE;
          end else if (swallow) begin
            slip_st_q <= STP_SLIP_DONE;
          end else begin
            slip_cnt_q <= slip_cnt_q + 2'h1;
          end
        end
        STP_SLIP_DONE: begin
          if (!slip_s2_q) begin
            slip_st_q <= STP_SLIP_IDLE;
          end
        end
        default: begin
          slip_st_q <= STP_SLIP_IDLE;
        end
      endcase
    end
  end

  // Divider counter; a swallowed clock holds it.
  logic [DIV_W-1:0] div_q;
  logic             word_end;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_q <= DIV_RST;
    end else if (!swallow) begin
      div_q <= div_q + 3'h1;
    end
  end

  assign word_end = !swallow && (mode_s2_q ? (div_q == LAST_BIT8)
                                           : (div_q[1:0] == LAST_BIT4[1:0]));

  // Shift register: newest bit enters at the top, oldest ends at bit 0.
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;

  assign shift_d = {serial_bit, shift_q[WORD_W-1:1]};

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      shift_q <= '0;
    end else if (!swallow) begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PARALLEL_OUTPUTS <= '0;
    end else if (word_end) begin
      PARALLEL_OUTPUTS <= shift_d;
    end
  end

  // Divided clocks: quarter rises with each four-bit word update.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      QUARTER_RATE_CLOCK_OUT <= 1'h0;
      EIGHTH_RATE_CLOCK_OUT  <= 1'h0;
    end else if (!swallow) begin
      QUARTER_RATE_CLOCK_OUT <= (div_q[1:0] == 2'h3) || (div_q[1:0] == 2'h0);
      EIGHTH_RATE_CLOCK_OUT  <= (div_q == 3'h7) || (div_q < 3'h3);
    end
  end

  a_quarter_phase: assert property (@(posedge CLK) disable iff (SYS_RST)
    (word_end && !mode_s2_q) |=> (QUARTER_RATE_CLOCK_OUT && !$past(QUARTER_RATE_CLOCK_OUT, 1)))
    else $error("quarter clock not rising at word update");

  a_word_load: assert property (@(posedge CLK) disable iff (SYS_RST)
    word_end |=> (PARALLEL_OUTPUTS[3] == $past(serial_bit, 1)))
    else $error("newest bit not on top output");

  a_out_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    !word_end |=> $stable(PARALLEL_OUTPUTS))
    else $error("outputs changed outside word update");

  a_mode8_gap: assert property (@(posedge CLK) disable iff (SYS_RST)
    (word_end && mode_s2_q) |=> !word_end [*7])
    else $error("eight bit mode updated early");

  a_mode4_gap: assert property (@(posedge CLK) disable iff (SYS_RST)
    (word_end && !mode_s2_q) |=> !word_end [*3])
    else $error("four bit mode updated early");

  a_swallow_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    swallow |=> (div_q == $past(div_q, 1)))
    else $error("divider advanced during swallow");

  a_one_slip: assert property (@(posedge CLK) disable iff (SYS_RST)
    swallow |=> !swallow)
    else $error("more than one swallow per pulse");

  a_slip_min: assert property (@(posedge CLK) disable iff (SYS_RST)
    swallow |-> ($past(slip_s2_q, 1) && slip_s2_q))
    else $error("swallow without two-clock pulse");

  a_div_count: assert property (@(posedge CLK) disable iff (SYS_RST)
    !swallow |=> (div_q == $past(div_q, 1) + 3'h1))
    else $error("divider did not advance");

  a_sel_route: assert property (@(posedge CLK) disable iff (SYS_RST)
    ser_s2_q.input_select |-> (serial_bit == ser_s2_q.first_serial_input))
    else $error("selector routed wrong input");

  a_reset_div: assert property (@(posedge CLK)
    SYS_RST |=> ((div_q == DIV_RST) && !QUARTER_RATE_CLOCK_OUT && !EIGHTH_RATE_CLOCK_OUT))
    else $error("reset did not clear dividers");

  a_eighth_phase: assert property (@(posedge CLK) disable iff (SYS_RST)
    (word_end && mode_s2_q) |=> (EIGHTH_RATE_CLOCK_OUT && !$past(EIGHTH_RATE_CLOCK_OUT, 1)))
    else $error("eighth clock not rising at word update");

  a_quarter_low: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!swallow && (div_q[1:0] == 2'h1)) |=> !QUARTER_RATE_CLOCK_OUT)
    else $error("quarter clock high in its low half");

  a_eighth_low: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!swallow && (div_q == 3'h3)) |=> !EIGHTH_RATE_CLOCK_OUT)
    else $error("eighth clock high in its low half");

  a_quarter_swallow: assert property (@(posedge CLK) disable iff (SYS_RST)
    swallow |=> $stable(QUARTER_RATE_CLOCK_OUT))
    else $error("quarter clock moved on swallowed clock");

  a_shift_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    swallow |=> $stable(shift_q))
    else $error("shift register moved on swallowed clock");

  a_slip_gap: assert property (@(posedge CLK) disable iff (SYS_RST)
    swallow |=> !swallow [*2])
    else $error("second swallow without a new pulse");

  a_slip_first: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(slip_s2_q) |-> !swallow)
    else $error("swallow on first cycle of slip pulse");

  a_word_bit0: assert property (@(posedge CLK) disable iff (SYS_RST)
    word_end |=> (PARALLEL_OUTPUTS[0] == $past(shift_q[1], 1)))
    else $error("oldest bit not on output zero");

endmodule

// ==== bench/stp_src.sv ====
`timescale 1ns/1ps
module stp_src
  import stp_pkg::*;
(
  // Clock, reset and pattern.
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [3:0]      word,
  input  wire logic            sel,
  // Serial lines.
  output stp_pkg::stp_serial_t ser
);
  logic [1:0] k_q;
  // Starts two bits ahead so that bit 0 meets divider count 0 after the two input flops.
  always @(posedge clk) k_q <= #1 rst ? 2'h2 : k_q + 2'h1;
  // The unused line carries the inverse bit.
  assign ser = sel ? {word[k_q], ~word[k_q], 1'b1} : {~word[k_q], word[k_q], 1'b0};
endmodule

// ==== bench/stp_conv_test.sv ====
`timescale 1ns/1ps
module stp_conv_test;
  import stp_pkg::*;
  logic        clk = 0;
  logic        rst = 1;
  logic        mode = 0;
  logic        slip = 0;
  logic        sel = 0;
  logic        per_on = 0;
  logic        qp = 0;
  logic        ep = 0;
  logic [3:0]  word = 4'h0;
  logic [3:0]  qv = 4'h0;
  logic [3:0]  q;
  logic        qck;
  logic        eck;
  logic [31:0] rnd = 32'h3;
  logic [3:0]  exp_q[$];
  stp_serial_t ser;
  int          err_count = 0;
  int          n_tests = 0;
  int          qn = 0;
  int          en = 0;
  always #20 clk = ~clk;
  stp_src i_src (.clk(clk), .rst(rst), .word(word), .sel(sel), .ser(ser));
  stp_conv i_dut (.CLK(clk), .SYS_RST(rst), .SERIAL_IN(ser), .CONV_MODE_8BIT(mode),
    .BIT_SLIP_INPUT(slip), .PARALLEL_OUTPUTS(q), .QUARTER_RATE_CLOCK_OUT(qck),
    .EIGHTH_RATE_CLOCK_OUT(eck));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int s);
    n_tests++;
    if (s != e) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  task automatic chk_lvl(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("Mismatches %0d of %0d comparisons.", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic note(input logic [3:0] w, input int n);
    step(12);
    repeat (n) exp_q.push_back(w);
    step(8 * n + 8);
  endtask
  // Watches the divided clocks and takes a note off the queue per quarter clock rise.
  always @(negedge clk) begin
    qn++;
    en++;
    if (q !== qv && !rst) chk_lvl("update phase", 1'h1, mode ? (eck && !ep) : (qck && !qp));
    if (qck && !qp) begin
      if (per_on) chk_cnt("quarter period", 4, qn);
      if (exp_q.size() > 0) chk("word", exp_q.pop_front(), q);
      qn = 0;
    end
    if (eck && !ep) begin
      if (per_on) chk_cnt("eighth period", 8, en);
      en = 0;
    end
    qp = qck;
    ep = eck;
    qv = q;
  end
  initial begin
    step(10);
    chk_lvl("quarter in reset", 1'h0, qck);
    chk_lvl("eighth in reset", 1'h0, eck);
    rst = 0;
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      word = rnd[3:0];
      sel = rnd[4];
      note(word, 2);
      per_on = 1;
    end
    per_on = 0;
    slip = 1;
    step(1);
    slip = 0;
    note(word, 1);
    slip = 1;
    step(2);
    slip = 0;
    note({word[0], word[3:1]}, 2);
    slip = 1;
    step(6);
    slip = 0;
    note({word[1:0], word[3:2]}, 2);
    rst = 1;
    step(3);
    chk_lvl("quarter in reset", 1'h0, qck);
    chk_lvl("eighth in reset", 1'h0, eck);
    rst = 0;
    note(word, 2);
    per_on = 1;
    mode = 1;
    note(word, 2);
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      word = rnd[3:0];
      sel = rnd[4];
      note(word, 2);
    end
    chk_cnt("words left", 0, exp_q.size());
    tally_and_finish;
  end
  initial begin
    #60000;
    err_count++;
    tally_and_finish;
  end
endmodule
